// File: isc_start_ctrl.v
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "isc_defs.vh"
module isc_start_ctrl #(
  parameter TICK_DIV = `ISC_TICK_CYC
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Serial clock line, open drain
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe_n,
  // Serial data line, open drain
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n
);

localparam integer HOLD_I = `ISC_HOLD_TK;
localparam integer SU_I = `ISC_SU_TK;
localparam [3:0] HOLD_TK = HOLD_I[3:0];
localparam [3:0] SU_TK = SU_I[3:0];

// Word-aligned address match
function reg_hit;
  input [7:0] a;
  input [7:0] o;
  begin
    reg_hit = (a[7:2] == o[7:2]);
  end
endfunction

// Synchronised lines and their last values
wire scl_s;
wire sda_s;
wire tick;
reg scl_d_reg;
reg sda_d_reg;

// Register state
reg ie_reg;
reg ack_reg;
reg stt_reg;
reg spt_reg;
reg rsv_reg;
reg start_failure_flag_reg;
reg busy_reg;
reg arb_reg;

// Controller state
reg [2:0] state_reg;
reg [2:0] state_next;
reg [3:0] cnt_reg;
reg [3:0] cnt_next;
reg scl_oe_n_next;
reg sda_oe_n_next;
reg stt_clr;
reg spt_clr;
reg start_failure_flag_set;
reg arb_set;
reg [7:0] rd_byte;

isc_sync u_scl_sync (
  .clk(pclk),
  .rst_n(presetn),
  .d(scl_in),
  .q(scl_s)
);

isc_sync u_sda_sync (
  .clk(pclk),
  .rst_n(presetn),
  .d(sda_in),
  .q(sda_s)
);

isc_tick #(
  .DIV(TICK_DIV)
) u_tick (
  .clk(pclk),
  .rst_n(presetn),
  .tick(tick)
);

// Bus conditions seen on the filtered lines
wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
wire tmo = tick & (cnt_reg == 4'h0);

// APB decode; one wait state, so every access takes two access cycles
wire apb_acc = psel & penable;
wire apb_done = apb_acc & pready;
wire apb_wr = apb_done & pwrite;
wire hit_ctl = reg_hit(paddr, `ISC_OFS_CTRL);
wire hit_flg = reg_hit(paddr, `ISC_OFS_FLAG);
wire hit_sta = reg_hit(paddr, `ISC_OFS_STAT);
wire mapped = hit_ctl | hit_flg | hit_sta;
wire wr_ctl = apb_wr & hit_ctl;
wire wr_flg = apb_wr & hit_flg;

// Trigger accepted only with the interface enabled in the same write
wire stt_set = wr_ctl & pwdata[`ISC_CTL_STT] & pwdata[`ISC_CTL_IE];
wire spt_set = wr_ctl & pwdata[`ISC_CTL_SPT] & pwdata[`ISC_CTL_IE];
wire lrel_w = wr_ctl & pwdata[`ISC_CTL_LREL];
wire dis_w = wr_ctl & ~pwdata[`ISC_CTL_IE];

// Read mux
always @* begin
  rd_byte = `ISC_RST_BYTE;
  if (hit_ctl) begin
    rd_byte[`ISC_CTL_IE] = ie_reg;
    rd_byte[`ISC_CTL_ACK] = ack_reg;
    rd_byte[`ISC_CTL_SPT] = spt_reg;
    rd_byte[`ISC_CTL_STT] = 1'b0;
  end else if (hit_flg) begin
    rd_byte[`ISC_FLG_START_FAILURE_FLAG] = start_failure_flag_reg;
    rd_byte[`ISC_FLG_BSY] = busy_reg;
    rd_byte[`ISC_FLG_RSV] = rsv_reg;
  end else if (hit_sta) begin
    rd_byte[`ISC_STA_MST] = (state_reg != `ISC_ST_IDLE);
    rd_byte[`ISC_STA_WAIT] = (state_reg == `ISC_ST_WAIT);
    rd_byte[`ISC_STA_PEND] = stt_reg;
    rd_byte[`ISC_STA_ARB] = arb_reg;
  end
end

// Bus slave handshake
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pready <= 1'b0;
    pslverr <= 1'b0;
    prdata <= `ISC_RST_WORD;
  end else begin
    pready <= apb_acc & ~pready;
    pslverr <= apb_acc & ~pready & ~mapped;
    if (apb_acc & ~pready & ~pwrite) begin
      prdata <= {24'h000000, rd_byte};
    end
  end
end

// Start, restart and stop sequencer
always @* begin
  state_next = state_reg;
  cnt_next = cnt_reg;
  scl_oe_n_next = scl_oe_n;
  sda_oe_n_next = sda_oe_n;
  stt_clr = 1'b0;
  spt_clr = 1'b0;
  start_failure_flag_set = 1'b0;
  arb_set = 1'b0;
  if (tick && cnt_reg != 4'h0) begin
    cnt_next = cnt_reg - 4'h1;
  end
  if ((!ie_reg && !wr_ctl) || lrel_w || dis_w) begin
    // Exit or disable releases both lines at once
    state_next = `ISC_ST_IDLE;
    scl_oe_n_next = 1'b1;
    sda_oe_n_next = 1'b1;
    stt_clr = 1'b1;
    spt_clr = 1'b1;
  end else begin
    case (state_reg)
      `ISC_ST_IDLE: begin
        // Nothing happens here without a pending trigger
        if (stt_reg) begin
          if (!busy_reg && !start_det) begin
            state_next = `ISC_ST_SDA_LO;
            sda_oe_n_next = 1'b0;
            cnt_next = HOLD_TK;
          end else if (rsv_reg) begin
            start_failure_flag_set = 1'b1;
            stt_clr = 1'b1;
          end
          // Otherwise the trigger stays as a reservation
        end
      end
      `ISC_ST_SDA_LO: begin
        // Hold time after the falling data edge, then clock low
        if (tmo) begin
          state_next = `ISC_ST_WAIT;
          scl_oe_n_next = 1'b0;
          stt_clr = 1'b1;
        end
      end
      `ISC_ST_WAIT: begin
        if (stt_reg) begin
          state_next = `ISC_ST_RS_SDA;
          sda_oe_n_next = 1'b1;
          cnt_next = SU_TK;
        end else if (spt_reg) begin
          state_next = `ISC_ST_SP_LO;
          sda_oe_n_next = 1'b0;
          cnt_next = SU_TK;
        end
      end
      `ISC_ST_RS_SDA: begin
        if (tmo) begin
          state_next = `ISC_ST_RS_SCL;
          scl_oe_n_next = 1'b1;
          cnt_next = SU_TK;
        end
      end
      `ISC_ST_RS_SCL: begin
        // Data low while released and clock high: another master won
        if (scl_s && !sda_s) begin
          state_next = `ISC_ST_IDLE;
          scl_oe_n_next = 1'b1;
          sda_oe_n_next = 1'b1;
          stt_clr = 1'b1;
          arb_set = 1'b1;
        end else if (tmo && scl_s) begin
          state_next = `ISC_ST_SDA_LO;
          sda_oe_n_next = 1'b0;
          cnt_next = HOLD_TK;
        end
      end
      `ISC_ST_SP_LO: begin
        if (tmo) begin
          state_next = `ISC_ST_SP_SCL;
          scl_oe_n_next = 1'b1;
          cnt_next = SU_TK;
        end
      end
      `ISC_ST_SP_SCL: begin
        // A stretching slave holds the clock low; wait for it
        if (tmo && scl_s) begin
          state_next = `ISC_ST_SP_END;
          sda_oe_n_next = 1'b1;
          spt_clr = 1'b1;
          cnt_next = SU_TK;
        end
      end
      `ISC_ST_SP_END: begin
        // Bus free time before a new start may follow
        if (tmo) begin
          state_next = `ISC_ST_IDLE;
        end
      end
      default: begin
        state_next = `ISC_ST_IDLE;
        scl_oe_n_next = 1'b1;
        sda_oe_n_next = 1'b1;
      end
    endcase
  end
end

// Registers and line drivers
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    state_reg <= `ISC_ST_IDLE;
    cnt_reg <= 4'h0;
    scl_oe_n <= 1'b1;
    sda_oe_n <= 1'b1;
    scl_out <= 1'b0;
    sda_out <= 1'b0;
    scl_d_reg <= 1'b1;
    sda_d_reg <= 1'b1;
    ie_reg <= 1'b0;
    ack_reg <= 1'b0;
    stt_reg <= 1'b0;
    spt_reg <= 1'b0;
    rsv_reg <= 1'b0;
    start_failure_flag_reg <= 1'b0;
    busy_reg <= 1'b0;
    arb_reg <= 1'b0;
  end else begin
    state_reg <= state_next;
    cnt_reg <= cnt_next;
    scl_oe_n <= scl_oe_n_next;
    sda_oe_n <= sda_oe_n_next;
    // Open drain: only the enable moves
    scl_out <= 1'b0;
    sda_out <= 1'b0;
    scl_d_reg <= scl_s;
    sda_d_reg <= sda_s;
    if (wr_ctl) begin
      ie_reg <= pwdata[`ISC_CTL_IE];
      ack_reg <= pwdata[`ISC_CTL_ACK];
    end
    // Hardware clear beats a software set in the same cycle
    if (stt_clr) begin
      stt_reg <= 1'b0;
    end else if (stt_set) begin
      stt_reg <= 1'b1;
    end
    if (spt_clr) begin
      spt_reg <= 1'b0;
    end else if (spt_set && !stt_set) begin
      // Start wins if both arrive together
      spt_reg <= 1'b1;
    end
    if (wr_flg) begin
      rsv_reg <= pwdata[`ISC_FLG_RSV];
    end
    // Failure flag: set wins over software clear
    if (start_failure_flag_set) begin
      start_failure_flag_reg <= 1'b1;
    end else if (wr_flg && !pwdata[`ISC_FLG_START_FAILURE_FLAG]) begin
      start_failure_flag_reg <= 1'b0;
    end
    if (arb_set) begin
      arb_reg <= 1'b1;
    end else if (stt_set) begin
      arb_reg <= 1'b0;
    end
    // Busy tracks the bus itself, own conditions included
    if (!ie_reg) begin
      busy_reg <= 1'b0;
    end else if (start_det) begin
      busy_reg <= 1'b1;
    end else if (stop_det) begin
      busy_reg <= 1'b0;
    end
  end
end

endmodule
`default_nettype wire

// File: isc_defs.vh
// Summary of operation
// - Trigger zero means no start condition.
// - Trigger on free bus starts master.
// - Data falls with clock high, then clock low.
// - Busy bus with reservation: start when freed.
// - Busy bus, reservation off: flag failure, clear.
// - Trigger during master wait gives restart.
// - Trigger cleared when reservation is prohibited.
// - Trigger cleared once start is generated.
// - Cleared on arbitration loss, exit, disable, reset.
// - Trigger ignored while interface disabled.
// - Trigger at bit one, reads zero.
// - Reservation-disable bit 0, failure flag bit 7.
`ifndef ISC_DEFS_VH
`define ISC_DEFS_VH

// Register byte offsets
`define ISC_OFS_CTRL 8'h00
`define ISC_OFS_FLAG 8'h04
`define ISC_OFS_STAT 8'h08

// Bus control register fields
`define ISC_CTL_IE 7
`define ISC_CTL_LREL 6
`define ISC_CTL_ACK 2
`define ISC_CTL_STT 1
`define ISC_CTL_SPT 0

// Interface flag register fields
`define ISC_FLG_START_FAILURE_FLAG 7
`define ISC_FLG_BSY 6
`define ISC_FLG_RSV 0

// Status register fields
`define ISC_STA_MST 0
`define ISC_STA_WAIT 1
`define ISC_STA_PEND 2
`define ISC_STA_ARB 3

// Reset values
`define ISC_RST_BYTE 8'h00
`define ISC_RST_WORD 32'h0000_0000

// Timing
`define ISC_CLK_NS 10
`define ISC_TICK_NS 1000
`define ISC_TICK_CYC (`ISC_TICK_NS / `ISC_CLK_NS)
`define ISC_T_HOLD_NS 4000
`define ISC_T_SU_NS 4700
`define ISC_HOLD_TK ((`ISC_T_HOLD_NS + `ISC_TICK_NS - 1) / `ISC_TICK_NS)
`define ISC_SU_TK ((`ISC_T_SU_NS + `ISC_TICK_NS - 1) / `ISC_TICK_NS)

// Controller states
`define ISC_ST_IDLE 3'h0
`define ISC_ST_SDA_LO 3'h1
`define ISC_ST_WAIT 3'h2
`define ISC_ST_RS_SDA 3'h3
`define ISC_ST_RS_SCL 3'h4
`define ISC_ST_SP_LO 3'h5
`define ISC_ST_SP_SCL 3'h6
`define ISC_ST_SP_END 3'h7

`endif

// File: isc_sync.v
`timescale 1ns/1ns
`default_nettype none
module isc_sync (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Asynchronous level in, filtered level out
  input wire d,
  output reg q
);

reg ff1_reg;
reg ff2_reg;
reg ff3_reg;

// Idle bus is high, so reset to one
always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    ff1_reg <= 1'b1;
    ff2_reg <= 1'b1;
    ff3_reg <= 1'b1;
    q <= 1'b1;
  end else begin
    ff1_reg <= d;
    ff2_reg <= ff1_reg;
    ff3_reg <= ff2_reg;
    if (ff2_reg == ff3_reg) begin
      q <= ff3_reg;
    end
  end
end

endmodule
`default_nettype wire

// File: isc_tick.v
`timescale 1ns/1ns
`default_nettype none
module isc_tick #(
  parameter DIV = 100
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // One-cycle enable every DIV cycles
  output reg tick
);

localparam integer LAST_I = DIV - 1;
localparam [15:0] LAST = LAST_I[15:0];

reg [15:0] cnt_reg;

always @(posedge clk or negedge rst_n) begin
  if (!rst_n) begin
    cnt_reg <= 16'h0000;
    tick <= 1'b0;
  end else if (cnt_reg == LAST) begin
    cnt_reg <= 16'h0000;
    tick <= 1'b1;
  end else begin
    cnt_reg <= cnt_reg + 16'h0001;
    tick <= 1'b0;
  end
end

endmodule
`default_nettype wire

// File: isc_far_master.sv
`timescale 1ns/1ns
`default_nettype none
module isc_far_master (
  // Pulls of the other master
  output var logic scl_oe_n,
  output var logic sda_oe_n
);
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end
  // Link phases of 125 ns, unrelated to pclk
  // Odd first step keeps pin changes off pclk edges
  task automatic bus_start();
    #127 sda_oe_n = 1'b0;
    #125 scl_oe_n = 1'b0;
  endtask
  // Data is still low from the start
  task automatic bus_stop();
    #127 scl_oe_n = 1'b1;
    #125 sda_oe_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: isc_start_ctrl_sva.sv
`timescale 1ns/1ns
`default_nettype none
module isc_chk #(
  parameter TICK_DIV = 100
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Lines
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n
);
  // Hold lasts up to five ticks
  localparam int HOLD_MAX = 6 * TICK_DIV;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_start;
    $fell(sda_oe_n) && scl_oe_n;
  endsequence
  property p_start_level;
    s_start |-> scl_in;
  endproperty
  a_start_level: assert property (p_start_level) else $error("data fell, clock low");
  property p_start_hold;
    s_start |-> scl_oe_n [*8] ##[1:HOLD_MAX] !scl_oe_n;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("clock not pulled after hold");
  property p_apb_lat;
    $rose(penable) && psel |=> pready;
  endproperty
  a_apb_lat: assert property (p_apb_lat) else $error("ready late");
  property p_apb_one;
    pready |=> !pready;
  endproperty
  a_apb_one: assert property (p_apb_one) else $error("ready too long");
  property p_apb_err;
    pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08});
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("wrong error response");
  property p_rd_ctl;
    pready && !pwrite && paddr == 8'h00 |-> !prdata[1];
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("trigger reads one");
  property p_dis_quiet;
    pready && pwrite && paddr == 8'h00 && !pwdata[7] |=> (!$fell(sda_oe_n)) [*4];
  endproperty
  a_dis_quiet: assert property (p_dis_quiet) else $error("start while disabled");
  property p_rst_rel;
    $rose(presetn) |-> sda_oe_n && scl_oe_n;
  endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("lines held after reset");
endmodule
bind isc_start_ctrl isc_chk #(.TICK_DIV(TICK_DIV)) u_chk (.*);
`default_nettype wire

// File: test_i2c_start_condition_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_i2c_start_condition_control;
  localparam int TD = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] rdv;
  logic err;
  wire [31:0] prdata;
  wire pready, pslverr, scl_out, sda_out, scl_oe_n, sda_oe_n, far_scl_n, far_sda_n;
  // Pull-ups: a line is low only while a party pulls it
  wire scl_line = (scl_oe_n | scl_out) & far_scl_n;
  wire sda_line = (sda_oe_n | sda_out) & far_sda_n;
  integer seed = 32;
  integer bad_count = 0;
  integer total_checks = 0;
  integer cycles = 0;
  integer m_busy = 0, m_fail = 0, m_rsv = 0;
  always #5 pclk = ~pclk;
  isc_start_ctrl #(.TICK_DIV(TD)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_line), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  isc_far_master far (.scl_oe_n(far_scl_n), .sda_oe_n(far_sda_n));
  function automatic logic [31:0] flag_exp();
    return {24'h000000, m_fail[0], m_busy[0], 5'h00, m_rsv[0]};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d bad %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // Upper data bits are random; only the low byte is meant
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    logic [31:0] rv;
    @(posedge pclk);
    rv = $random(seed);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {rv[31:8], d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 8'h00);
    chk(rdv, e);
    chk({31'h0, err}, {31'h0, a > 8'h08});
  endtask
  task automatic oe(input logic c, input logic d);
    chk({30'h0, scl_oe_n, sda_oe_n}, {30'h0, c, d});
    chk({30'h0, scl_out, sda_out}, 32'h0000_0000);
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, flag_exp());
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    $display("done reset");
    apb(8'h00, 1'b1, 8'h02);
    repeat (10) @(posedge pclk);
    oe(1'b1, 1'b1);
    rd(8'h00, 32'h0);
    apb(8'h00, 1'b1, 8'h86);
    @(posedge pclk);
    #1;
    oe(1'b1, 1'b0);
    repeat (30) @(posedge pclk);
    oe(1'b0, 1'b0);
    m_busy = 1;
    rd(8'h00, 32'h84);
    rd(8'h04, flag_exp());
    rd(8'h08, 32'h03);
    apb(8'h00, 1'b1, 8'h82);
    repeat (100) @(posedge pclk);
    oe(1'b0, 1'b0);
    rd(8'h00, 32'h80);
    apb(8'h00, 1'b1, 8'h85);
    repeat (120) @(posedge pclk);
    m_busy = 0;
    oe(1'b1, 1'b1);
    rd(8'h04, flag_exp());
    $display("done master");
    far.bus_start();
    m_busy = 1;
    m_rsv = 1;
    apb(8'h04, 1'b1, 8'h01);
    apb(8'h00, 1'b1, 8'h82);
    repeat (10) @(posedge pclk);
    oe(1'b1, 1'b1);
    m_fail = 1;
    rd(8'h04, flag_exp());
    rd(8'h00, 32'h80);
    m_fail = 0;
    apb(8'h04, 1'b1, 8'h01);
    rd(8'h04, flag_exp());
    m_rsv = 0;
    apb(8'h04, 1'b1, 8'h00);
    apb(8'h00, 1'b1, 8'h82);
    repeat (20) @(posedge pclk);
    oe(1'b1, 1'b1);
    rd(8'h08, 32'h04);
    far.bus_stop();
    repeat (10) @(posedge pclk);
    oe(1'b1, 1'b0);
    repeat (30) @(posedge pclk);
    oe(1'b0, 1'b0);
    rd(8'h00, 32'h80);
    $display("done busy");
    apb(8'h00, 1'b1, 8'hC0);
    repeat (3) @(posedge pclk);
    oe(1'b1, 1'b1);
    rd(8'h00, 32'h80);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    m_busy = 0;
    rd(8'h04, flag_exp());
    $display("done exit");
    report_and_stop();
  end
endmodule
`default_nettype wire
